// ### verilog/wws_top.sv
`timescale 1ns/1ps
// How it works
// - Two windowed units, each prescaler plus counter
// - Restart before window opens counts as failure
// - Failure requests firmware or power-on reset
// - Per-unit cause flag records reset source
// - Counting clock: scaled system, RTC, power
// - Always-on unit restarted, else resets, flags
// - Always-on unit keeps counting in sleep
// - Always-on period up to eight seconds, coarse
// - Either sleep state freezes the windowed units
module wws_top
	import wws_pkg::*;
#(
	parameter int CW = 32,
	parameter int PW = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic [wws_pkg::WWS_AW-1:0] addr,
	input wire logic [wws_pkg::WWS_DW-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [wws_pkg::WWS_DW-1:0] rd_data,
	// Counting clock ticks, one cycle each
	input wire logic rtc_tick,
	input wire logic pm_tick,
	// Sleep state of the surrounding chip
	input wire logic deepest_sleep_state,
	input wire logic retention_sleep_state,
	// Requests to the system reset controller
	output logic fw_reset_req,
	output logic por_reset_req,
	// Interrupt
	output logic irq
);
	import wws_pkg::*;

	if (CW < 8 || CW > WWS_DW || PW < 1 || PW > 16) begin : g_bad
		$error("wws_top: CW must be 8..32 and PW 1..16");
	end

	// Register address match
	function automatic logic hit(input logic [WWS_AW-1:0] a, input logic [WWS_AW-1:0] off);
		hit = (a == off);
	endfunction

	// Base address of windowed unit i
	function automatic logic [WWS_AW-1:0] win_base(input int i);
		win_base = WWS_AW'(i) * WWS_WIN_STRIDE;
	endfunction

	// Tick of the selected counting clock; the spare code never counts
	function automatic logic pick_tick(input wws_clksel_t s, input logic rt, input logic pm);
		logic t;
		t = 1'b0;
		unique case (s)
			WWS_CLK_SYS: t = 1'b1;
			WWS_CLK_RTC: t = rt;
			WWS_CLK_PM: t = pm;
			default: t = 1'b0;
		endcase
		pick_tick = t;
	endfunction

	// Windowed unit registers
	wws_win_ctrl_t ctrl_r [WWS_NWIN]; // Control word per unit
	logic [CW-1:0] tout_r [WWS_NWIN]; // Timeout in counts
	logic [CW-1:0] win_r [WWS_NWIN]; // Earliest legal restart count
	logic [WWS_NWIN-1:0] restart; // Restart strobe per unit
	logic [WWS_NWIN-1:0] win_exp; // Expiry pulse per unit
	logic [WWS_NWIN-1:0] win_early; // Early restart pulse per unit
	logic [CW-1:0] win_cnt [WWS_NWIN]; // Live count per unit

	// Always-on unit registers
	wws_aon_ctrl_t aon_ctrl_r; // Always-on control
	logic aon_restart; // Always-on restart strobe
	logic aon_exp; // Always-on expiry pulse
	logic [WWS_AON_CW-1:0] aon_cnt; // Always-on live count

	// Shared state
	logic [WWS_NCAUSE-1:0] cause_r; // Reset cause flags, kept past the reset
	logic [WWS_NEV-1:0] stat_r; // Sticky interrupt status
	logic [WWS_NEV-1:0] mask_r; // Interrupt enables
	logic [WWS_NEV-1:0] events; // This cycle's events
	logic [WWS_NWIN-1:0] win_fail; // Any failure of a windowed unit
	logic any_fail; // Some unit asks for a reset
	logic frozen; // Windowed logic held static
	logic [WWS_DW-1:0] rd_nxt; // Read mux output
	logic [WWS_DW-1:0] rd_data_r; // Registered read data
	logic fw_req_r; // Firmware reset request
	logic por_req_r; // Power-on reset request
	logic irq_r; // Interrupt level

	// Both sleep states stop the core-side logic
	assign frozen = deepest_sleep_state || retention_sleep_state;

	genvar gi;
	generate
		for (gi = 0; gi < WWS_NWIN; gi++) begin : g_win
			logic tick_g; // Gated tick of this unit

			// Clock source choice, stopped in sleep
			assign tick_g = !frozen && pick_tick(ctrl_r[gi].clksel, rtc_tick, pm_tick);

			// Restart strobe; ignored while disabled
			assign restart[gi] = wr_en && ctrl_r[gi].en &&
				hit(addr, win_base(gi) + WWS_OFF_RESTART);

			// Control register; a requested reset disables the unit
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					ctrl_r[gi] <= wws_win_ctrl_t'(WWS_RST_CTRL);
				end else if (any_fail) begin
					ctrl_r[gi].en <= 1'b0; // Unit restarts disabled, like after reset
				end else if (wr_en && hit(addr, win_base(gi) + WWS_OFF_CTRL)) begin
					ctrl_r[gi] <= wws_win_ctrl_t'(wr_data);
					ctrl_r[gi].rsvd <= '0; // Reserved bits read zero
					ctrl_r[gi].prescale <= wr_data[WWS_DW-1 -: 16] & 16'(PW == 16 ?
						16'hFFFF : ((17'h1 << PW) - 17'h1));
				end
			end

			// Timeout register
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					tout_r[gi] <= WWS_RST_TIMEOUT[CW-1:0];
				end else if (wr_en && hit(addr, win_base(gi) + WWS_OFF_TIMEOUT)) begin
					tout_r[gi] <= wr_data[CW-1:0];
				end
			end

			// Window register
			always_ff @(posedge clk or posedge reset) begin
				if (reset) begin
					win_r[gi] <= WWS_RST_WINDOW[CW-1:0];
				end else if (wr_en && hit(addr, win_base(gi) + WWS_OFF_WINDOW)) begin
					win_r[gi] <= wr_data[CW-1:0];
				end
			end

			// Counting core of this unit
			wws_win_core #(
				.CW(CW),
				.PW(PW)
			) u_core (
				.clk(clk),
				.reset(reset),
				.tick(tick_g),
				.en(ctrl_r[gi].en),
				.win_en(ctrl_r[gi].win_en),
				.prescale(ctrl_r[gi].prescale[PW-1:0]),
				.timeout(tout_r[gi]),
				.window(win_r[gi]),
				.restart(restart[gi]),
				.count(win_cnt[gi]),
				.expired(win_exp[gi]),
				.early(win_early[gi])
			);

			// Early restart is a timeout as well
			// A unit already disabled by another failure adds no second request
			assign win_fail[gi] = ctrl_r[gi].en && (win_exp[gi] || win_early[gi]);
		end
	endgenerate

	// Always-on restart strobe, only while enabled
	assign aon_restart = wr_en && aon_ctrl_r.en && hit(addr, WWS_ADDR_AON_RESTART);

	// Always-on control register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			aon_ctrl_r <= wws_aon_ctrl_t'(WWS_RST_CTRL);
		end else if (any_fail) begin
			aon_ctrl_r.en <= 1'b0;
		end else if (wr_en && hit(addr, WWS_ADDR_AON_CTRL)) begin
			aon_ctrl_r <= wws_aon_ctrl_t'(wr_data);
			aon_ctrl_r.rsvd <= '0;
		end
	end

	// Always-on core sees the raw RTC tick, never the sleep gate
	wws_aon_core #(
		.CW(WWS_AON_CW)
	) u_aon (
		.clk(clk),
		.reset(reset),
		.tick(rtc_tick),
		.en(aon_ctrl_r.en),
		.sel(aon_ctrl_r.sel),
		.restart(aon_restart),
		.count(aon_cnt),
		.expired(aon_exp)
	);

	// Event vector in status layout
	assign events = {aon_exp, win_early[1], win_early[0], win_exp[1], win_exp[0]};
	assign any_fail = |win_fail || (aon_exp && aon_ctrl_r.en);

	// Reset requests, one pulse per failing cycle; a tie of kinds asks power-on
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fw_req_r <= 1'b0;
			por_req_r <= 1'b0;
		end else begin
			por_req_r <= (win_fail[0] && ctrl_r[0].rst_por) ||
				(win_fail[1] && ctrl_r[1].rst_por) ||
				(aon_exp && aon_ctrl_r.en && aon_ctrl_r.rst_por);
			fw_req_r <= any_fail && !((win_fail[0] && ctrl_r[0].rst_por) ||
				(win_fail[1] && ctrl_r[1].rst_por) ||
				(aon_exp && aon_ctrl_r.en && aon_ctrl_r.rst_por));
		end
	end

	// Cause flags: write one to clear; of the resets only this block's own clears them, so they
	// survive the system reset that a failure triggers. Set beats clear.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cause_r <= '0;
		end else begin
			for (int i = 0; i < WWS_NCAUSE; i++) begin
				if (wr_en && hit(addr, WWS_ADDR_CAUSE) && wr_data[i]) begin
					cause_r[i] <= 1'b0;
				end
			end
			for (int i = 0; i < WWS_NWIN; i++) begin
				if (win_fail[i]) begin
					cause_r[i] <= 1'b1;
				end
			end
			if (aon_exp && aon_ctrl_r.en) begin
				cause_r[WWS_CAUSE_AON] <= 1'b1;
			end
		end
	end

	// Sticky interrupt status, write one to clear, set wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			stat_r <= '0;
		end else begin
			for (int i = 0; i < WWS_NEV; i++) begin
				if (events[i]) begin
					stat_r[i] <= 1'b1;
				end else if (wr_en && hit(addr, WWS_ADDR_IRQ_STATUS) && wr_data[i]) begin
					stat_r[i] <= 1'b0;
				end
			end
		end
	end

	// Interrupt mask
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mask_r <= '0;
		end else if (wr_en && hit(addr, WWS_ADDR_IRQ_MASK)) begin
			mask_r <= wr_data[WWS_NEV-1:0];
		end
	end

	// Interrupt level, one cycle behind the status
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(stat_r & mask_r);
		end
	end

	// Read mux; unmapped and write-only addresses read zero
	always_comb begin
		rd_nxt = WWS_RD_ZERO;
		for (int i = 0; i < WWS_NWIN; i++) begin
			if (hit(addr, win_base(i) + WWS_OFF_CTRL)) begin
				rd_nxt = ctrl_r[i];
			end
			if (hit(addr, win_base(i) + WWS_OFF_TIMEOUT)) begin
				rd_nxt = WWS_DW'(tout_r[i]);
			end
			if (hit(addr, win_base(i) + WWS_OFF_WINDOW)) begin
				rd_nxt = WWS_DW'(win_r[i]);
			end
			if (hit(addr, win_base(i) + WWS_OFF_COUNT)) begin
				rd_nxt = WWS_DW'(win_cnt[i]);
			end
		end
		if (hit(addr, WWS_ADDR_AON_CTRL)) begin
			rd_nxt = aon_ctrl_r;
		end
		if (hit(addr, WWS_ADDR_AON_COUNT)) begin
			rd_nxt = WWS_DW'(aon_cnt);
		end
		if (hit(addr, WWS_ADDR_CAUSE)) begin
			rd_nxt = WWS_DW'(cause_r);
		end
		if (hit(addr, WWS_ADDR_IRQ_STATUS)) begin
			rd_nxt = WWS_DW'(stat_r);
		end
		if (hit(addr, WWS_ADDR_IRQ_MASK)) begin
			rd_nxt = WWS_DW'(mask_r);
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rd_data_r <= WWS_RD_ZERO;
		end else begin
			rd_data_r <= rd_en ? rd_nxt : WWS_RD_ZERO;
		end
	end

	// Outputs straight from flip-flops
	assign rd_data = rd_data_r;
	assign fw_reset_req = fw_req_r;
	assign por_reset_req = por_req_r;
	assign irq = irq_r;
endmodule

// ### verilog/wws_pkg.sv
package wws_pkg;
	// Register bus geometry
	localparam int WWS_AW = 8;
	localparam int WWS_DW = 32;
	localparam int WWS_NWIN = 2;

	// Windowed watchdog register offsets, relative to each unit's base
	localparam logic [WWS_AW-1:0] WWS_OFF_CTRL = 8'h00;
	localparam logic [WWS_AW-1:0] WWS_OFF_TIMEOUT = 8'h04;
	localparam logic [WWS_AW-1:0] WWS_OFF_WINDOW = 8'h08;
	localparam logic [WWS_AW-1:0] WWS_OFF_RESTART = 8'h0C;
	localparam logic [WWS_AW-1:0] WWS_OFF_COUNT = 8'h10;
	// Unit a at base 00, unit b one stride above
	localparam logic [WWS_AW-1:0] WWS_WIN_STRIDE = 8'h20;

	// Always-on watchdog and shared registers
	localparam logic [WWS_AW-1:0] WWS_ADDR_AON_CTRL = 8'h40;
	localparam logic [WWS_AW-1:0] WWS_ADDR_AON_RESTART = 8'h44;
	localparam logic [WWS_AW-1:0] WWS_ADDR_AON_COUNT = 8'h48;
	localparam logic [WWS_AW-1:0] WWS_ADDR_CAUSE = 8'h4C;
	localparam logic [WWS_AW-1:0] WWS_ADDR_IRQ_STATUS = 8'h50;
	localparam logic [WWS_AW-1:0] WWS_ADDR_IRQ_MASK = 8'h54;

	// Counting clock of a windowed unit
	typedef enum logic [1:0] {
		WWS_CLK_SYS = 2'b00,
		WWS_CLK_RTC = 2'b01,
		WWS_CLK_PM = 2'b10,
		WWS_CLK_NONE = 2'b11
	} wws_clksel_t;

	// Windowed unit control word, bit 0 upward: en, win_en, rst_por, clksel
	typedef struct packed {
		logic [15:0] prescale;
		logic [10:0] rsvd;
		wws_clksel_t clksel;
		logic rst_por;
		logic win_en;
		logic en;
	} wws_win_ctrl_t;

	// Always-on control word: en, rst_por, period select
	typedef struct packed {
		logic [25:0] rsvd;
		logic [3:0] sel;
		logic rst_por;
		logic en;
	} wws_aon_ctrl_t;

	// Event bits, shared by status and mask layouts; cause has its own three bits
	localparam int WWS_NEV = 5;
	localparam int WWS_EV_EXP_A = 0;
	localparam int WWS_EV_EXP_B = 1;
	localparam int WWS_EV_EARLY_A = 2;
	localparam int WWS_EV_EARLY_B = 3;
	localparam int WWS_EV_AON = 4;
	localparam int WWS_NCAUSE = 3;
	localparam int WWS_CAUSE_AON = 2;

	// Reset values
	localparam logic [WWS_DW-1:0] WWS_RST_CTRL = 32'h0000_0000;
	localparam logic [WWS_DW-1:0] WWS_RST_TIMEOUT = 32'hFFFF_FFFF;
	localparam logic [WWS_DW-1:0] WWS_RST_WINDOW = 32'h0000_0000;
	localparam logic [WWS_DW-1:0] WWS_RD_ZERO = 32'h0000_0000;

	// Always-on period: 2**(sel + base) ticks of the 32768 Hz clock
	localparam int WWS_RTC_HZ = 32768;
	localparam int WWS_AON_MAX_S = 8;
	localparam int WWS_AON_MAX_TICKS = WWS_AON_MAX_S * WWS_RTC_HZ;
	localparam int WWS_AON_SEL_MAX = 15;
	localparam int WWS_AON_BASE = $clog2(WWS_AON_MAX_TICKS) - WWS_AON_SEL_MAX;
	localparam int WWS_AON_CW = $clog2(WWS_AON_MAX_TICKS) + 1;
endpackage

// ### verilog/wws_win_core.sv
`timescale 1ns/1ps
// One windowed watchdog: prescaler, up counter, window check
module wws_win_core #(
	parameter int CW = 32,
	parameter int PW = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Configuration
	input wire logic tick,
	input wire logic en,
	input wire logic win_en,
	input wire logic [PW-1:0] prescale,
	input wire logic [CW-1:0] timeout,
	input wire logic [CW-1:0] window,
	input wire logic restart,
	// Status
	output logic [CW-1:0] count,
	output logic expired,
	output logic early
);
	logic [PW-1:0] pre_r; // Prescaler phase
	logic [CW-1:0] cnt_r; // Timeout counter
	logic step; // One count of the main counter

	if (CW < 8 || PW < 1) begin : g_bad
		$error("wws_win_core: widths too small");
	end

	// Counter advances once per prescale+1 ticks
	assign step = en && tick && (pre_r == prescale);
	assign count = cnt_r;

	// Prescaler, held at zero while disabled
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pre_r <= '0;
		end else if (!en || restart) begin
			pre_r <= '0;
		end else if (tick) begin
			pre_r <= (pre_r == prescale) ? '0 : pre_r + 1'b1;
		end
	end

	// Main counter; a restart reloads the full period
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_r <= '0;
		end else if (!en || restart || expired) begin
			cnt_r <= '0;
		end else if (step) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Expiry pulse; >= covers a timeout lowered below the count
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			expired <= 1'b0;
		end else begin
			expired <= en && !restart && !expired && step && (cnt_r >= timeout);
		end
	end

	// Restart before the window opens is a failure
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			early <= 1'b0;
		end else begin
			early <= en && restart && win_en && (cnt_r < window);
		end
	end
endmodule

// ### verilog/wws_aon_core.sv
`timescale 1ns/1ps
// Always-on watchdog: counts 32768 Hz ticks regardless of sleep state
module wws_aon_core
	import wws_pkg::*;
#(
	parameter int CW = WWS_AON_CW
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Control
	input wire logic tick,
	input wire logic en,
	input wire logic [3:0] sel,
	input wire logic restart,
	// Status
	output logic [CW-1:0] count,
	output logic expired
);
	logic [CW-1:0] cnt_r; // Tick counter
	logic [CW-1:0] limit; // Selected period in ticks

	if (CW < WWS_AON_BASE + WWS_AON_SEL_MAX + 1) begin : g_bad
		$error("wws_aon_core: counter cannot reach the longest period");
	end

	// Coarse power-of-two periods only, enough for hang recovery
	assign limit = CW'(1) << (CW'(sel) + CW'(WWS_AON_BASE));
	assign count = cnt_r;

	// Counter, reloaded by restart, idle while disabled
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_r <= '0;
		end else if (!en || restart || expired) begin
			cnt_r <= '0;
		end else if (tick) begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	// Expiry once the period is used up
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			expired <= 1'b0;
		end else begin
			expired <= en && !restart && !expired && tick && (cnt_r >= limit - 1'b1);
		end
	end
endmodule

// ### dv/wws_sys_model.sv
`timescale 1ns/1ps
// System side: tick sources and the reset controller
module wws_sys_model #(
	parameter int RTC_DIV = 4,
	parameter int PM_DIV = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Tick sources
	input wire logic rtc_run,
	output logic rtc_tick,
	output logic pm_tick,
	// Reset controller
	input wire logic fw_reset_req,
	input wire logic por_reset_req,
	output int fw_cnt,
	output int por_cnt
);
	int rc; // Rtc divider
	int pc; // Pm divider
	// One-cycle ticks; rtc can be stopped so sleep checks see a quiet window
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rc <= 0;
			pc <= 0;
			rtc_tick <= 1'b0;
			pm_tick <= 1'b0;
		end else begin
			rc <= (rc == RTC_DIV - 1) ? 0 : rc + 1;
			pc <= (pc == PM_DIV - 1) ? 0 : pc + 1;
			rtc_tick <= rtc_run && (rc == RTC_DIV - 1);
			pm_tick <= (pc == PM_DIV - 1);
		end
	end
	// Controller tallies each request pulse
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fw_cnt <= 0;
			por_cnt <= 0;
		end else begin
			fw_cnt <= fw_cnt + int'(fw_reset_req);
			por_cnt <= por_cnt + int'(por_reset_req);
		end
	end
endmodule

// ### dv/wws_top_monitor.sv
`timescale 1ns/1ps
// Port checker for the watchdog set
module wws_top_monitor
	import wws_pkg::*;
#(
	parameter int CW = 32,
	parameter int PW = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Register port
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [wws_pkg::WWS_DW-1:0] rd_data,
	// Ticks and sleep
	input wire logic rtc_tick,
	input wire logic deepest_sleep_state,
	input wire logic retention_sleep_state,
	// Outputs
	input wire logic fw_reset_req,
	input wire logic por_reset_req,
	input wire logic irq
);
	logic req; // Any reset request
	logic armed_r; // Write seen since last request
	logic arm_d_r; // Armed, one cycle older
	logic seen_r; // Some request since reset
	assign req = fw_reset_req | por_reset_req;
	// Failure disables every unit, so a new request needs a new write
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			armed_r <= 1'b0;
			arm_d_r <= 1'b0;
			seen_r <= 1'b0;
		end else begin
			armed_r <= wr_en | (armed_r & ~req);
			arm_d_r <= armed_r;
			seen_r <= seen_r | req;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_fw_pulse: assert property (fw_reset_req |=> !fw_reset_req)
		else $error("firmware request longer than one cycle");
	a_por_pulse: assert property (por_reset_req |=> !por_reset_req)
		else $error("power-on request longer than one cycle");
	a_one_kind: assert property (!(fw_reset_req && por_reset_req))
		else $error("both reset kinds at once");
	a_req_armed: assert property (req |-> arm_d_r)
		else $error("request with no enabling write");
	a_rd_window: assert property (rd_data != 32'h0000_0000 |-> $past(rd_en))
		else $error("read data outside its cycle");
	a_irq_source: assert property ($rose(irq) |-> ##[0:2] seen_r)
		else $error("interrupt without a failure");
	a_irq_falls: assert property ($fell(irq) |-> $past(wr_en) || $past(wr_en, 2))
		else $error("flag dropped without software");
	a_sleep_frozen: assert property (((deepest_sleep_state || retention_sleep_state)
		&& !rtc_tick && !wr_en) [*6] |-> !req)
		else $error("request while frozen");
	c_fw: cover property (fw_reset_req);
	c_por: cover property (por_reset_req);
	c_irq: cover property ($rose(irq));
endmodule

bind wws_top wws_top_monitor #(.CW(CW), .PW(PW)) i_mon (.*);

// ### dv/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the watchdog set
module tb_top;
	import wws_pkg::*;
	// Design inputs, valued from time zero
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [WWS_AW-1:0] addr = 8'h00;
	logic [WWS_DW-1:0] wr_data = 32'h0000_0000;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic deepest_sleep_state = 1'b0;
	logic retention_sleep_state = 1'b0;
	logic rtc_run = 1'b1; // Rtc gate in the partner
	// Outputs
	logic [WWS_DW-1:0] rd_data;
	logic rtc_tick, pm_tick, fw_reset_req, por_reset_req, irq;
	int fw_cnt, por_cnt;
	int num_errors = 0;
	int total_checks = 0;

	always #4 clk = ~clk;

	wws_top i_dut (.*);
	wws_sys_model i_sys (.*);

	// Counts, verdict, end of run
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Value compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// Unit base address
	function automatic logic [7:0] ub(input int u);
		return (u == 1) ? WWS_WIN_STRIDE : 8'h00;
	endfunction
	// One-cycle write
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wr_data <= v;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	// Read, data settles in the next cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1;
		chk(rd_data, exp);
	endtask
	// Enable unit a, then reload its count
	task automatic en(input logic [31:0] v);
		wr(WWS_OFF_CTRL, v);
		wr(WWS_OFF_RESTART, 32'h0000_0000);
	endtask
	// No request for n cycles
	task automatic quiet(input int n);
		logic hit;
		hit = 1'b0;
		repeat (n) begin
			@(posedge clk);
			#1;
			hit = hit | fw_reset_req | por_reset_req;
		end
		chk(hit, 1'b0);
	endtask
	// Request of kind p after lo..hi cycles; a miss ends the run
	task automatic expect_req(input int lo, input int hi, input logic p);
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (!(fw_reset_req | por_reset_req) && n < hi);
		if (!(fw_reset_req | por_reset_req)) begin
			num_errors++;
			$display("[FAIL] %0t no reset request", $time);
			give_verdict();
		end
		chk(n >= lo, 1'b1);
		chk({por_reset_req, fw_reset_req}, {p, ~p});
	endtask
	// Clear cause and status flags
	task automatic clr();
		wr(WWS_ADDR_CAUSE, 32'h0000_001F);
		wr(WWS_ADDR_IRQ_STATUS, 32'h0000_001F);
	endtask

	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		// Reset values, unmapped read
		for (int u = 0; u < 2; u++) begin
			rd(ub(u) + WWS_OFF_CTRL, WWS_RST_CTRL);
			rd(ub(u) + WWS_OFF_TIMEOUT, WWS_RST_TIMEOUT);
			rd(ub(u) + WWS_OFF_WINDOW, WWS_RST_WINDOW);
		end
		rd(WWS_ADDR_CAUSE, WWS_RD_ZERO);
		rd(8'h3C, WWS_RD_ZERO);
		wr(WWS_ADDR_IRQ_MASK, 32'h0000_001F);
		// Expiry: unit a asks firmware reset, unit b power-on
		for (int u = 0; u < 2; u++) begin
			wr(ub(u) + WWS_OFF_TIMEOUT, 32'h0000_0002);
			wr(ub(u) + WWS_OFF_CTRL, (u == 1) ? 32'h0000_0005 : 32'h0000_0001);
			expect_req(2, 10, u[0]);
			wr(WWS_ADDR_IRQ_MASK, 32'h0000_0000);
			rd(WWS_ADDR_IRQ_STATUS, 32'h0000_0001 << u);
			chk(irq, 1'b0);
			wr(WWS_ADDR_IRQ_MASK, 32'h0000_001F);
			rd(WWS_ADDR_CAUSE, 32'h0000_0001 << u);
			chk(irq, 1'b1);
			clr();
			rd(WWS_ADDR_CAUSE, WWS_RD_ZERO);
			chk(irq, 1'b0);
		end
		// Prescaler slows steps; timely restarts hold expiry off
		wr(WWS_OFF_TIMEOUT, 32'h0000_0003);
		wr(WWS_OFF_CTRL, 32'h0001_0001);
		repeat (6) begin
			wr(WWS_OFF_RESTART, 32'h0000_0000);
			quiet(3);
		end
		expect_req(6, 6, 1'b0);
		clr();
		// Counting clock rtc, pm, then none
		for (int cs = 1; cs < 4; cs++) begin
			en((cs << 3) | 32'h0000_0001);
			if (cs == 3) begin
				quiet(60);
			end else begin
				expect_req(10, 80, 1'b0);
				clr();
			end
		end
		// Window bit without enable stays idle
		wr(WWS_OFF_CTRL, 32'h0000_0002);
		quiet(20);
		rd(WWS_OFF_COUNT, WWS_RD_ZERO);
		// Restart before the window opens fails
		wr(WWS_OFF_TIMEOUT, 32'h0000_0028);
		wr(WWS_OFF_WINDOW, 32'h0000_0014);
		en(32'h0000_0003);
		expect_req(1, 4, 1'b0);
		rd(WWS_ADDR_IRQ_STATUS, 32'h0000_0001 << WWS_EV_EARLY_A);
		rd(WWS_ADDR_CAUSE, 32'h0000_0001);
		clr();
		// Restart inside the window is accepted
		wr(WWS_OFF_CTRL, 32'h0000_0003);
		repeat (30) @(posedge clk);
		wr(WWS_OFF_RESTART, 32'h0000_0000);
		rd(WWS_OFF_COUNT, 32'h0000_0001);
		quiet(30);
		// Both sleep states freeze the windowed unit
		rtc_run <= 1'b0;
		wr(WWS_OFF_TIMEOUT, 32'h0000_0002);
		for (int s = 0; s < 2; s++) begin
			deepest_sleep_state <= (s == 0);
			retention_sleep_state <= (s == 1);
			en(32'h0000_0001);
			quiet(40);
			@(posedge clk);
			deepest_sleep_state <= 1'b0;
			retention_sleep_state <= 1'b0;
			expect_req(2, 12, 1'b0);
			clr();
		end
		// Always-on unit keeps counting in deepest sleep
		rtc_run <= 1'b1;
		deepest_sleep_state <= 1'b1;
		wr(WWS_ADDR_AON_CTRL, 32'hFFFF_FFFF);
		rd(WWS_ADDR_AON_CTRL, 32'h0000_003F);
		wr(WWS_ADDR_AON_CTRL, 32'h0000_0001);
		repeat (6) begin
			wr(WWS_ADDR_AON_RESTART, 32'h0000_0000);
			quiet(16);
		end
		expect_req(8, 30, 1'b0);
		rd(WWS_ADDR_CAUSE, 32'h0000_0001 << WWS_CAUSE_AON);
		clr();
		wr(WWS_ADDR_AON_CTRL, 32'h0000_0003);
		wr(WWS_ADDR_AON_RESTART, 32'h0000_0000);
		expect_req(24, 45, 1'b1);
		rd(WWS_ADDR_AON_COUNT, WWS_RD_ZERO);
		clr();
		deepest_sleep_state <= 1'b0;
		chk(fw_cnt, 32'h0000_0008);
		chk(por_cnt, 32'h0000_0002);
		give_verdict();
	end
endmodule
